// ==== design/gsl_pkg.sv ====
package gsl_pkg;
    // ---------------------------------------------------------------
    // channel and data geometry
    // ---------------------------------------------------------------
    localparam int GSL_CHANNELS = 24;
    localparam int GSL_BITS = 12;
    localparam int GSL_SR_W = GSL_CHANNELS * GSL_BITS;
    localparam logic [GSL_BITS-1:0] GSL_CNT_MAX = 12'hfff;
    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int GSL_CLK_MHZ = 200;
    localparam int GSL_OSC_MHZ = 4;
    localparam int GSL_PWM_DIV = GSL_CLK_MHZ / GSL_OSC_MHZ;
    // ---------------------------------------------------------------
    // serial event kinds carried through the buffer
    // ---------------------------------------------------------------
    localparam int GSL_EV_W = 2;
    localparam logic [GSL_EV_W-1:0] GSL_EV_RISE = 2'h0;
    localparam logic [GSL_EV_W-1:0] GSL_EV_FALL = 2'h1;
    localparam logic [GSL_EV_W-1:0] GSL_EV_LATCH = 2'h2;
    localparam int GSL_BUF_DEPTH = 2;
endpackage

// ==== design/gsl_evt_if.sv ====
interface gsl_evt_if;
    import gsl_pkg::*;
    logic valid;
    logic ready;
    logic [GSL_EV_W-1:0] kind;
    logic sbit;
    modport src (output valid, output kind, output sbit, input ready);
    modport snk (input valid, input kind, input sbit, output ready);
endinterface

// ==== design/gsl_evt_buf.sv ====
module gsl_evt_buf #(
    parameter int DEPTH = gsl_pkg::GSL_BUF_DEPTH
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    gsl_evt_if.snk up,
    gsl_evt_if.src dn
);
    import gsl_pkg::*;
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    typedef logic [GSL_EV_W:0] gsl_ent_t;

    gsl_ent_t mem_ff [DEPTH];
    gsl_ent_t nxt_mem [DEPTH];
    logic [AW-1:0] wr_ff, rd_ff, nxt_wr, nxt_rd;
    logic [AW:0] cnt_ff, nxt_cnt;
    logic push, pop;

    assign up.ready = cnt_ff != (AW+1)'(DEPTH);
    assign dn.valid = cnt_ff != '0;
    assign dn.kind = mem_ff[rd_ff][GSL_EV_W:1];
    assign dn.sbit = mem_ff[rd_ff][0];

    always_comb begin
        push = up.valid && up.ready;
        pop = dn.valid && dn.ready;
        nxt_mem = mem_ff;
        nxt_wr = wr_ff;
        nxt_rd = rd_ff;
        nxt_cnt = cnt_ff;
        if (push) begin
            nxt_mem[wr_ff] = {up.kind, up.sbit};
            nxt_wr = (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
        end
        if (pop) begin
            nxt_rd = (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
        end
        if (push && !pop) begin
            nxt_cnt = cnt_ff + 1'b1;
        end else if (pop && !push) begin
            nxt_cnt = cnt_ff - 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_ff[i] <= '0;
            end
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end else begin
            mem_ff <= nxt_mem;
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
            cnt_ff <= nxt_cnt;
        end
    end
endmodule

// ==== design/gsl_top.sv ====
// Behaviour
// - each serial clock rise not in the same cycle as a latch rise captures the serial input into the shift LSB.
// - each serial clock rise not in the same cycle as a latch rise moves the whole shift register one bit up.
// - cascade stage takes the shift MSB on each serial clock fall not in the same cycle as a latch rise.
// - latch strobe rise copies the whole shift register into the latch.
// - after a latch rise all outputs stay off until next period.
// - latch strobe rise leaves the grayscale counter running, not cleared.
// - blank high forces outputs off, resets timing, holds counter at zero.
// - blank low lets each output follow its latched grayscale value.
// - 24 channels, 4096 duty steps, PWM repeats from latched data.
module gsl_top #(
    parameter int PWM_DIV = gsl_pkg::GSL_PWM_DIV
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic serial_clk,
    input wire logic serial_bit_input,
    input wire logic latch_strobe,
    input wire logic blank,
    output logic cascade_bit_output,
    output logic [gsl_pkg::GSL_CHANNELS-1:0] channel_sink_output,
    output logic event_overrun
);
    import gsl_pkg::*;
    localparam int DW = (PWM_DIV > 1) ? $clog2(PWM_DIV) : 1;

    // ---------------------------------------------------------------
    // pin synchronisers and edge detection
    // ---------------------------------------------------------------
    logic [3:0] meta_ff, sync_ff;
    logic prev_sclk_ff, prev_lat_ff;
    logic sclk_rise, sclk_fall, lat_rise, blank_s;
    logic ovr_ff, nxt_ovr;

    gsl_evt_if ev_in ();
    gsl_evt_if ev_out ();

    gsl_evt_buf #(
        .DEPTH(GSL_BUF_DEPTH)
    ) u_buf (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .up(ev_in),
        .dn(ev_out)
    );

    always_comb begin
        blank_s = sync_ff[3];
        sclk_rise = sync_ff[0] && !prev_sclk_ff;
        sclk_fall = !sync_ff[0] && prev_sclk_ff;
        lat_rise = sync_ff[2] && !prev_lat_ff;
        // a same-cycle serial rise is only possible if the host breaks
        // the settle time after a latch, so the latch is queued and that serial edge is dropped
        ev_in.valid = sclk_rise || sclk_fall || lat_rise;
        ev_in.kind = lat_rise ? GSL_EV_LATCH :
                     (sclk_rise ? GSL_EV_RISE : GSL_EV_FALL);
        ev_in.sbit = sync_ff[1];
        nxt_ovr = ovr_ff || (ev_in.valid && !ev_in.ready);
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            meta_ff <= '0;
            sync_ff <= '0;
            prev_sclk_ff <= 1'b0;
            prev_lat_ff <= 1'b0;
            ovr_ff <= 1'b0;
        end else begin
            meta_ff <= {blank, latch_strobe, serial_bit_input, serial_clk};
            sync_ff <= meta_ff;
            prev_sclk_ff <= sync_ff[0];
            prev_lat_ff <= sync_ff[2];
            ovr_ff <= nxt_ovr;
        end
    end

    // ---------------------------------------------------------------
    // shift register, cascade stage and grayscale latch
    // ---------------------------------------------------------------
    logic [GSL_SR_W-1:0] sr_ff, nxt_sr, lat_ff, nxt_lat;
    logic casc_ff, nxt_casc, stall_ff, nxt_stall;
    logic take_rise, take_fall, take_lat;

    // the stall cycle after a latch copy lets back-pressure reach the
    // buffer; serial edges are far apart so nothing is lost
    assign ev_out.ready = !stall_ff;

    always_comb begin
        take_rise = ev_out.valid && ev_out.ready &&
                    ev_out.kind == GSL_EV_RISE;
        take_fall = ev_out.valid && ev_out.ready &&
                    ev_out.kind == GSL_EV_FALL;
        take_lat = ev_out.valid && ev_out.ready &&
                   ev_out.kind == GSL_EV_LATCH;
        nxt_sr = sr_ff;
        nxt_casc = casc_ff;
        nxt_lat = lat_ff;
        nxt_stall = take_lat;
        if (take_rise) begin
            nxt_sr = {sr_ff[GSL_SR_W-2:0], ev_out.sbit};
        end
        if (take_fall) begin
            nxt_casc = sr_ff[GSL_SR_W-1];
        end
        if (take_lat) begin
            nxt_lat = sr_ff;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sr_ff <= '0;
            lat_ff <= '0;
            casc_ff <= 1'b0;
            stall_ff <= 1'b0;
        end else begin
            sr_ff <= nxt_sr;
            lat_ff <= nxt_lat;
            casc_ff <= nxt_casc;
            stall_ff <= nxt_stall;
        end
    end

    // ---------------------------------------------------------------
    // grayscale pwm timing
    // ---------------------------------------------------------------
    logic [DW-1:0] div_ff, nxt_div;
    logic [GSL_BITS-1:0] cnt_ff, nxt_cnt;
    logic hold_ff, nxt_hold, tick, wrap;
    logic [GSL_CHANNELS-1:0] cmp, out_ff, nxt_out;

    genvar g;
    generate
        for (g = 0; g < GSL_CHANNELS; g++) begin : g_ch
            assign cmp[g] = cnt_ff < lat_ff[g*GSL_BITS +: GSL_BITS];
        end
    endgenerate

    always_comb begin
        tick = div_ff == DW'(PWM_DIV-1);
        wrap = tick && cnt_ff == GSL_CNT_MAX;
        nxt_div = tick ? '0 : div_ff + 1'b1;
        // counter is free running; a latch never touches it
        nxt_cnt = tick ? cnt_ff + 1'b1 : cnt_ff;
        nxt_hold = hold_ff;
        if (wrap) begin
            nxt_hold = 1'b0;
        end
        if (take_lat) begin
            nxt_hold = 1'b1;
        end
        if (blank_s) begin
            nxt_div = '0;
            nxt_cnt = '0;
            nxt_hold = 1'b0;
        end
        nxt_out = (blank_s || nxt_hold) ? '0 : cmp;
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            div_ff <= '0;
            cnt_ff <= '0;
            hold_ff <= 1'b0;
            out_ff <= '0;
        end else begin
            div_ff <= nxt_div;
            cnt_ff <= nxt_cnt;
            hold_ff <= nxt_hold;
            out_ff <= nxt_out;
        end
    end

    assign cascade_bit_output = casc_ff;
    assign channel_sink_output = out_ff;
    assign event_overrun = ovr_ff;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    sequence s_latch_hold;
        take_lat ##1 hold_ff;
    endsequence

    sequence s_blank_clear;
        blank_s ##1 (cnt_ff == '0 && div_ff == '0);
    endsequence

    AST_SHIFT_IN: assert property (
        take_rise |=> sr_ff[0] == $past(ev_out.sbit))
        else $error("serial bit not captured at lsb");
    AST_SHIFT_UP: assert property (
        take_rise |=> sr_ff[GSL_SR_W-1:1] == $past(sr_ff[GSL_SR_W-2:0]))
        else $error("shift register did not move up");
    AST_CASC_LOAD: assert property (
        take_fall |=> cascade_bit_output == $past(sr_ff[GSL_SR_W-1]))
        else $error("cascade stage missed msb on fall");
    AST_CASC_HOLD: assert property (
        !take_fall |=> $stable(cascade_bit_output))
        else $error("cascade output changed without a fall");
    AST_LATCH_COPY: assert property (
        take_lat |=> lat_ff == $past(sr_ff))
        else $error("latch did not copy shift register");
    AST_OFF_AFTER_LATCH: assert property (
        take_lat && !blank_s |-> s_latch_hold ##0
            (channel_sink_output == '0))
        else $error("outputs not off after latch");
    AST_HOLD_TO_PERIOD: assert property (
        hold_ff && !wrap && !blank_s && !take_lat |=> hold_ff &&
            channel_sink_output == '0)
        else $error("outputs released before next period");
    AST_CNT_KEEP: assert property (
        take_lat && !blank_s |=> cnt_ff == $past(cnt_ff) ||
            cnt_ff == GSL_BITS'($past(cnt_ff) + 1'b1))
        else $error("latch disturbed grayscale counter");
    AST_BLANK: assert property (
        blank_s |-> s_blank_clear ##0 (channel_sink_output == '0))
        else $error("blank did not clear timing and outputs");
    AST_PWM_CH0: assert property (
        !blank_s && !nxt_hold |=>
            channel_sink_output[0] == $past(cnt_ff < lat_ff[11:0]))
        else $error("channel output disagrees with its level");
    AST_WRAP: assert property (
        wrap && !blank_s && !take_lat |=> cnt_ff == '0 && !hold_ff)
        else $error("counter did not wrap to a new period");
endmodule

// ==== test/gsl_host_model.sv ====
module gsl_host_model (
    input logic clk_sys,
    output logic serial_clk,
    output logic serial_bit_input,
    output logic latch_strobe
);
    timeunit 1ns;
    timeprecision 100ps;
    import gsl_pkg::*;
    // ---------------------------------------------------------------
    // serial load, 16 system clocks (80 ns) per bit, clock parked low
    // between frames; every pin moves just after a system clock rise
    // ---------------------------------------------------------------
    initial begin
        serial_clk = 1'b0;
        serial_bit_input = 1'b0;
        latch_strobe = 1'b0;
    end
    // top bit first, so the first bit sent ends in the top stage
    // the leading edge wait keeps a back-to-back call from touching a
    // pin twice in one time step
    task automatic load(input logic [GSL_SR_W-1:0] v);
        @(posedge clk_sys);
        for (int i = GSL_SR_W - 1; i >= 0; i--) begin
            serial_bit_input <= v[i];
            repeat (4) @(posedge clk_sys);
            serial_clk <= 1'b1;
            repeat (8) @(posedge clk_sys);
            serial_clk <= 1'b0;
            repeat (4) @(posedge clk_sys);
        end
        // released data line must not keep showing the last bit
        serial_bit_input <= ~serial_bit_input;
    endtask
    task automatic latch();
        @(posedge clk_sys);
        latch_strobe <= 1'b1;
        repeat (8) @(posedge clk_sys);
        latch_strobe <= 1'b0;
        repeat (20) @(posedge clk_sys);
    endtask
endmodule

// ==== test/test_grayscale_shift_latch.sv ====
module test_grayscale_shift_latch;
    timeunit 1ns;
    timeprecision 100ps;
    import gsl_pkg::*;
    localparam int DIV = 2;
    localparam int PERIOD = 4096 * DIV;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic blank = 1'b0;
    logic serial_clk;
    logic serial_bit_input;
    logic latch_strobe;
    logic cascade_bit_output;
    logic [GSL_CHANNELS-1:0] channel_sink_output;
    logic event_overrun;
    logic [GSL_SR_W-1:0] img;
    int fail_count = 0;
    int n_checks = 0;
    int cyc = 0;
    always #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) cyc <= cyc + 1;
    gsl_top #(.PWM_DIV(DIV)) u_gsl_top (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .serial_clk(serial_clk),
        .serial_bit_input(serial_bit_input),
        .latch_strobe(latch_strobe),
        .blank(blank),
        .cascade_bit_output(cascade_bit_output),
        .channel_sink_output(channel_sink_output),
        .event_overrun(event_overrun)
    );
    gsl_host_model u_gsl_host (
        .clk_sys(clk_sys),
        .serial_clk(serial_clk),
        .serial_bit_input(serial_bit_input),
        .latch_strobe(latch_strobe)
    );
    // ---------------------------------------------------------------
    // shared helpers
    // ---------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic tick();
        @(posedge clk_sys);
        #1;
    endtask
    task automatic wait_on(input int ch, output int t);
        t = 0;
        while (channel_sink_output[ch] !== 1'b1 && t < 3 * PERIOD) begin
            tick();
            t++;
        end
    endtask
    // on-time of every channel over one period, from its first cycle
    task automatic count_period(input logic [GSL_SR_W-1:0] v);
        int cnt [GSL_CHANNELS];
        cnt = '{default: 0};
        repeat (PERIOD) begin
            for (int n = 0; n < GSL_CHANNELS; n++) begin
                cnt[n] += (channel_sink_output[n] === 1'b1);
            end
            tick();
        end
        for (int n = 0; n < GSL_CHANNELS; n++) begin
            check("on cycles", 32'(v[12*n +: 12]) * DIV, cnt[n]);
        end
    endtask
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic test_shift_cascade();
        u_gsl_host.load(img);
        fork
            u_gsl_host.load(img);
            for (int j = 0; j < GSL_SR_W; j++) begin
                @(negedge serial_clk);
                repeat (7) tick();
                check("cascade", (j == GSL_SR_W - 1) ? img[GSL_SR_W - 1]
                      : img[GSL_SR_W - 2 - j], cascade_bit_output);
            end
        join
    endtask
    task automatic test_latch_pwm();
        int t;
        int t0;
        u_gsl_host.latch();
        wait_on(23, t);
        check("first period seen", 1, t < 3 * PERIOD);
        count_period(img);
        t0 = cyc;
        repeat (100) tick();
        u_gsl_host.load(~img);
        u_gsl_host.latch();
        repeat (8) tick();
        check("off after latch", 0, channel_sink_output);
        // a cleared counter would push the restart over half a period late
        wait_on(0, t);
        check("restart at wrap", 1,
              (cyc - t0 >= PERIOD - 4) && (cyc - t0 <= PERIOD + 4));
        count_period(~img);
    endtask
    task automatic test_blank();
        int t;
        @(posedge clk_sys);
        blank <= 1'b1;
        repeat (6) tick();
        check("blank off", 0, channel_sink_output);
        repeat (300) tick();
        check("blank still off", 0, channel_sink_output);
        @(posedge clk_sys);
        blank <= 1'b0;
        wait_on(0, t);
        check("start after blank", 1, t <= 8);
        count_period(~img);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        for (int n = 0; n < GSL_CHANNELS; n++) begin
            img[12*n +: 12] = 12'(n * 178);
        end
        repeat (16) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        test_shift_cascade();
        test_latch_pwm();
        test_blank();
        check("overrun", 0, event_overrun);
        results();
    end
    // the run needs about 50k cycles; this leaves margin below the 90k-cycle watchdog
    initial begin
        #450000;
        fail_count++;
        $display("BAD watchdog expected done seen timeout");
        results();
    end
endmodule
